// file: design/nvm_id_pkg.sv
`default_nettype none
package nvm_id_pkg;

    // Register window reached through the serial register interface
    localparam logic [3:0]  MMS_SELECT          = 4'hc;
    localparam logic [15:0] OFF_ADDR_UPPER      = 16'h1003;
    localparam logic [15:0] OFF_WAFER_POS       = 16'h1004;
    localparam logic [15:0] OFF_HEALTH          = 16'h1005;

    // Field positions
    localparam int ADDR_UPPER_LSB = 0;
    localparam int WAFER_COL_LSB  = 0;
    localparam int WAFER_ROW_LSB  = 8;
    localparam int RED_SBE_BIT    = 15;
    localparam int RED_DBE_BIT    = 14;
    localparam int YEL_SBE_BIT    = 13;
    localparam int YEL_DBE_BIT    = 12;
    localparam int GRN_SBE_BIT    = 11;
    localparam int GRN_DBE_BIT    = 10;
    localparam int RSVD_WIDTH     = 10;

    // Reset values
    localparam logic [15:0] READ_RESET   = 16'h0000;
    localparam logic [5:0]  FLAGS_RESET  = 6'h00;

    // Configuration memory shape: 16 data bits, 5 check bits, 1 parity
    localparam int DATA_W  = 16;
    localparam int CODE_W  = 22;
    localparam int DEPTH   = 8;
    localparam int IDX_W   = 3;
    localparam logic [2:0] LAST_WORD = 3'h7;

    // Word placement; zone follows the word index
    localparam logic [2:0] W_WAFER    = 3'h0;
    localparam logic [2:0] W_RSVD     = 3'h1;
    localparam logic [2:0] W_ADDR_UP  = 3'h2;
    localparam logic [2:0] W_TRIM     = 3'h4;
    localparam logic [2:0] FIRST_YEL  = 3'h2;
    localparam logic [2:0] FIRST_RED  = 3'h4;

    // Reference rate of the block clock
    localparam int CLK_HZ = 100_000_000;

    typedef enum logic [2:0] {
        ZONE_GREEN  = 3'b001,
        ZONE_YELLOW = 3'b010,
        ZONE_RED    = 3'b100
    } zone_t;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_DONE = 2'b10
    } load_state_t;

    function automatic zone_t zone_of(input logic [2:0] idx);
        if (idx >= FIRST_RED)
            return ZONE_RED;
        else if (idx >= FIRST_YEL)
            return ZONE_YELLOW;
        else
            return ZONE_GREEN;
    endfunction

    // Hamming positions 1..21, overall parity in bit 0
    function automatic logic [21:0] secded_encode(input logic [15:0] d);
        logic [21:0] c;
        int          j;
        c = 22'h000000;
        j = 0;
        for (int p = 1; p < CODE_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                c[p] = d[j];
                j++;
            end
        end
        for (int k = 0; k < 5; k++) begin
            for (int p = 1; p < CODE_W; p++) begin
                if ((((p >> k) & 1) == 1) && (p != (1 << k)))
                    c[1 << k] = c[1 << k] ^ c[p];
            end
        end
        c[0] = ^c[21:1];
        return c;
    endfunction

endpackage
`default_nettype wire

// file: design/nvm_word_if.sv
`timescale 1ns/1ps
`default_nettype none
interface nvm_word_if;
    import nvm_id_pkg::*;

    logic [IDX_W-1:0]  addr;
    logic [CODE_W-1:0] code;
    logic [DATA_W-1:0] data;
    logic              sbe;
    logic              dbe;

    modport store (input addr, output code);
    modport dec   (input code, output data, sbe, dbe);
    modport ctrl  (output addr, input data, sbe, dbe);
endinterface
`default_nettype wire

// file: design/nvm_store.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_store
    import nvm_id_pkg::*;
#(
    parameter logic [DEPTH*DATA_W-1:0] CONTENT   = '0,
    parameter logic [DEPTH*CODE_W-1:0] FLIP_MASK = '0
) (
    nvm_word_if.store port
);
    logic [CODE_W-1:0] mem [DEPTH];

    // Factory image, no write path exists at all
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = secded_encode(CONTENT[i*DATA_W +: DATA_W])
                   ^ FLIP_MASK[i*CODE_W +: CODE_W];
        end
    end

    assign port.code = mem[port.addr];
endmodule
`default_nettype wire

// file: design/secded_decode.sv
`timescale 1ns/1ps
`default_nettype none
module secded_decode
    import nvm_id_pkg::*;
(
    nvm_word_if.dec port
);
    // Single errors fixed, double errors flagged
    always_comb begin
        logic [4:0]        syn;
        logic              par;
        logic [CODE_W-1:0] fixed;
        int                j;
        syn   = 5'h00;
        par   = ^port.code;
        fixed = port.code;
        j     = 0;
        for (int k = 0; k < 5; k++) begin
            for (int p = 1; p < CODE_W; p++) begin
                if (((p >> k) & 1) == 1)
                    syn[k] = syn[k] ^ port.code[p];
            end
        end
        port.sbe = 1'b0;
        port.dbe = 1'b0;
        if (par) begin
            // Syndrome past the code length means more than one flip
            if (syn < 5'(CODE_W)) begin
                port.sbe = 1'b1;
                fixed[syn] = ~port.code[syn];
            end else begin
                port.dbe = 1'b1;
            end
        end else if (syn != 5'h00) begin
            port.dbe = 1'b1;
        end
        port.data = 16'h0000;
        for (int p = 1; p < CODE_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                port.data[j] = fixed[p];
                j++;
            end
        end
    end
endmodule
`default_nettype wire

// file: design/nvm_id_health.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_id_health
    import nvm_id_pkg::*;
#(
    parameter logic [DEPTH*DATA_W-1:0] CONTENT   = 128'h0,
    parameter logic [DEPTH*CODE_W-1:0] FLIP_MASK = 176'h0
) (
    input  wire logic                CLK,
    input  wire logic                RST,
    input  wire logic                RD_REQ,
    input  wire logic [3:0]          RD_MMS,
    input  wire logic [15:0]         RD_ADDR,
    output var  logic                RD_ACK,
    output var  logic [15:0]         RD_DATA,
    output var  logic                RD_ERR,
    output var  logic                LOAD_DONE,
    output var  logic                ADDR_VALID,
    output var  logic                CFG_GUARANTEED,
    output var  logic [DATA_W-1:0]   CFG_TRIM
);
    import nvm_id_pkg::*;

    // Single clock domain for the whole block
    nvm_word_if nvm ();

    nvm_store #(
        .CONTENT   (CONTENT),
        .FLIP_MASK (FLIP_MASK)
    ) u_store (
        .port (nvm)
    );

    secded_decode u_dec (
        .port (nvm)
    );

    load_state_t       state;
    load_state_t       next_state;
    logic [IDX_W-1:0]  idx;
    logic [IDX_W-1:0]  next_idx;
    logic [7:0]        addr_upper;
    logic [7:0]        next_addr_upper;
    logic [6:0]        wafer_row;
    logic [6:0]        next_wafer_row;
    logic [6:0]        wafer_col;
    logic [6:0]        next_wafer_col;
    logic [9:0]        rsvd;
    logic [9:0]        next_rsvd;
    logic [5:0]        flags;
    logic [5:0]        next_flags;
    logic [DATA_W-1:0] trim;
    logic [DATA_W-1:0] next_trim;
    zone_t             zone;

    assign nvm.addr = idx;
    assign zone     = zone_of(idx);

    // Loader walks every word once after reset, then holds
    always_comb begin
        next_state      = state;
        next_idx        = idx;
        next_addr_upper = addr_upper;
        next_wafer_row  = wafer_row;
        next_wafer_col  = wafer_col;
        next_rsvd       = rsvd;
        next_flags      = flags;
        next_trim       = trim;
        unique case (state)
            ST_LOAD: begin
                // Flags only ever set, so nothing can be lost
                unique case (zone)
                    ZONE_RED: begin
                        next_flags[RED_SBE_BIT-GRN_DBE_BIT] =
                            flags[RED_SBE_BIT-GRN_DBE_BIT] | nvm.sbe;
                        next_flags[RED_DBE_BIT-GRN_DBE_BIT] =
                            flags[RED_DBE_BIT-GRN_DBE_BIT] | nvm.dbe;
                    end
                    ZONE_YELLOW: begin
                        next_flags[YEL_SBE_BIT-GRN_DBE_BIT] =
                            flags[YEL_SBE_BIT-GRN_DBE_BIT] | nvm.sbe;
                        next_flags[YEL_DBE_BIT-GRN_DBE_BIT] =
                            flags[YEL_DBE_BIT-GRN_DBE_BIT] | nvm.dbe;
                    end
                    ZONE_GREEN: begin
                        next_flags[GRN_SBE_BIT-GRN_DBE_BIT] =
                            flags[GRN_SBE_BIT-GRN_DBE_BIT] | nvm.sbe;
                        next_flags[0] = flags[0] | nvm.dbe;
                    end
                endcase
                // Corrected data is still latched, even when flagged bad
                if (idx == W_WAFER) begin
                    next_wafer_row = nvm.data[WAFER_ROW_LSB +: 7];
                    next_wafer_col = nvm.data[WAFER_COL_LSB +: 7];
                end
                if (idx == W_RSVD)
                    next_rsvd = nvm.data[RSVD_WIDTH-1:0];
                if (idx == W_ADDR_UP)
                    next_addr_upper = nvm.data[ADDR_UPPER_LSB +: 8];
                if (idx == W_TRIM)
                    next_trim = nvm.data;
                if (idx == LAST_WORD)
                    next_state = ST_DONE;
                else
                    next_idx = idx + 3'h1;
            end
            ST_DONE: begin
                next_idx = idx;
            end
            default: begin
                next_state = ST_LOAD;
                next_idx   = 3'h0;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state      <= ST_LOAD;
            idx        <= 3'h0;
            addr_upper <= 8'h00;
            wafer_row  <= 7'h00;
            wafer_col  <= 7'h00;
            rsvd       <= 10'h000;
            flags      <= FLAGS_RESET;
            trim       <= 16'h0000;
        end else begin
            state      <= next_state;
            idx        <= next_idx;
            addr_upper <= next_addr_upper;
            wafer_row  <= next_wafer_row;
            wafer_col  <= next_wafer_col;
            rsvd       <= next_rsvd;
            flags      <= next_flags;
            trim       <= next_trim;
        end
    end

    logic              next_ack;
    logic              next_err;
    logic [15:0]       next_data;
    logic              next_done;
    logic              next_addr_valid;
    logic              next_guaranteed;
    logic [DATA_W-1:0] next_cfg_trim;

    // Read decode; a read changes no state, and no write path exists
    always_comb begin
        next_ack  = RD_REQ;
        next_err  = 1'b0;
        next_data = READ_RESET;
        if (RD_REQ) begin
            if (RD_MMS == MMS_SELECT && RD_ADDR == OFF_ADDR_UPPER) begin
                next_data = {8'h00, addr_upper};
            end else if (RD_MMS == MMS_SELECT &&
                         RD_ADDR == OFF_WAFER_POS) begin
                next_data = {1'b0, wafer_row, 1'b0, wafer_col};
            end else if (RD_MMS == MMS_SELECT &&
                         RD_ADDR == OFF_HEALTH) begin
                next_data = {flags, rsvd};
            end else begin
                next_err = 1'b1;
            end
        end
        next_done       = (state == ST_DONE);
        // Bad address data is reported, operation carries on
        next_addr_valid = (state == ST_DONE) &&
                          !flags[YEL_DBE_BIT-GRN_DBE_BIT];
        // Red double error only withdraws the guarantee
        next_guaranteed = (state == ST_DONE) &&
                          !flags[RED_DBE_BIT-GRN_DBE_BIT];
        next_cfg_trim   = trim;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            RD_ACK         <= 1'b0;
            RD_ERR         <= 1'b0;
            RD_DATA        <= READ_RESET;
            LOAD_DONE      <= 1'b0;
            ADDR_VALID     <= 1'b0;
            CFG_GUARANTEED <= 1'b0;
            CFG_TRIM       <= 16'h0000;
        end else begin
            RD_ACK         <= next_ack;
            RD_ERR         <= next_err;
            RD_DATA        <= next_data;
            LOAD_DONE      <= next_done;
            ADDR_VALID     <= next_addr_valid;
            CFG_GUARANTEED <= next_guaranteed;
            CFG_TRIM       <= next_cfg_trim;
        end
    end
endmodule
`default_nettype wire

// file: tb/nvm_id_health_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_id_health_monitor
    import nvm_id_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        RD_REQ,
    input wire logic [3:0]  RD_MMS,
    input wire logic [15:0] RD_ADDR,
    input wire logic        RD_ACK,
    input wire logic [15:0] RD_DATA,
    input wire logic        RD_ERR,
    input wire logic        LOAD_DONE,
    input wire logic        ADDR_VALID,
    input wire logic        CFG_GUARANTEED,
    input wire logic [15:0] CFG_TRIM
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // A read aimed at this block's selector
    wire logic hit = RD_REQ && RD_MMS == MMS_SELECT;

    // Read port timing
    a_ack_follows:
        assert property (RD_REQ |=> RD_ACK)
        else $error("read not answered next cycle");
    a_no_stray_ack:
        assert property (!RD_REQ |=> !RD_ACK && !RD_ERR)
        else $error("answer without a read");
    a_idle_zero:
        assert property (!RD_ACK |-> RD_DATA == 16'h0000)
        else $error("read data not cleared");
    a_unmapped_refused:
        assert property (RD_REQ && RD_MMS != MMS_SELECT
            |=> RD_ERR && RD_DATA == 16'h0000)
        else $error("foreign selector not refused");
    // Register layout
    a_upper_pad:
        assert property (hit && RD_ADDR == OFF_ADDR_UPPER
            |=> RD_DATA[15:8] == 8'h00 && !RD_ERR)
        else $error("upper address byte not clear");
    a_wafer_pad:
        assert property (hit && RD_ADDR == OFF_WAFER_POS
            |=> !RD_DATA[15] && !RD_DATA[7] && !RD_ERR)
        else $error("wafer pad bits not zero");
    a_red_error:
        assert property (hit && RD_ADDR == OFF_HEALTH && LOAD_DONE
            |=> RD_DATA[RED_DBE_BIT] != $past(CFG_GUARANTEED))
        else $error("red error flag disagrees with status");
    a_yellow_error:
        assert property (hit && RD_ADDR == OFF_HEALTH && LOAD_DONE
            |=> RD_DATA[YEL_DBE_BIT] != $past(ADDR_VALID))
        else $error("yellow error flag disagrees with status");
    // Load sequence and sticky results
    a_load_time:
        assert property ($fell(RST)
            |-> !LOAD_DONE [*8] ##1 !LOAD_DONE ##1 LOAD_DONE)
        else $error("load did not finish on time");
    a_status_hold:
        assert property (LOAD_DONE |=> LOAD_DONE && $stable(CFG_TRIM)
            && $stable({ADDR_VALID, CFG_GUARANTEED}))
        else $error("loaded status changed");

    // Main scenarios reached
    c_health: cover property (hit && RD_ADDR == OFF_HEALTH ##1 RD_ACK);
    c_unmapped: cover property (RD_ERR);
    c_red_lost: cover property (LOAD_DONE && !CFG_GUARANTEED);
endmodule

bind nvm_id_health nvm_id_health_monitor i_mon (
    .CLK(CLK), .RST(RST), .RD_REQ(RD_REQ), .RD_MMS(RD_MMS),
    .RD_ADDR(RD_ADDR), .RD_ACK(RD_ACK), .RD_DATA(RD_DATA),
    .RD_ERR(RD_ERR), .LOAD_DONE(LOAD_DONE), .ADDR_VALID(ADDR_VALID),
    .CFG_GUARANTEED(CFG_GUARANTEED), .CFG_TRIM(CFG_TRIM)
);
`default_nettype wire

// file: tb/nvm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_host_model (
    input  wire logic        clk,
    output var  logic        rd_req,
    output var  logic [3:0]  rd_mms,
    output var  logic [15:0] rd_addr,
    input  wire logic        rd_ack,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_err
);
    logic [7:0] station_upper;

    // Bus idle from time zero
    initial begin
        rd_req = 1'b0;
        rd_mms = 4'h0;
        rd_addr = 16'h0000;
    end

    // One read; the answer is taken at the next falling edge
    task automatic read(input logic [3:0] mms, input logic [15:0] addr,
                        output logic [15:0] data, output logic err,
                        output logic ok);
        @(negedge clk);
        rd_req = 1'b1;
        rd_mms = mms;
        rd_addr = addr;
        @(negedge clk);
        ok = rd_ack;
        data = rd_data;
        err = rd_err;
        rd_req = 1'b0;
        // Inverse on idle, so a stale select is never mistaken
        rd_mms = ~mms;
        rd_addr = ~addr;
        // Only the low byte joins the assembled station address
        if (ok && !err && mms == 4'hc && addr == 16'h1003)
            station_upper = data[7:0];
    endtask
endmodule
`default_nettype wire

// file: tb/nvm_id_health_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_id_health_tb_top;
    import nvm_id_pkg::*;
    typedef struct packed {
        logic [3:0]  mms;
        logic [15:0] addr;
        logic [15:0] data;
        logic        err;
    } row_t;
    // Factory image; word 1 low bits are the reserved health content
    localparam logic [127:0] IMAGE =
        128'h0000_0000_0000_1234_0000_5a77_fdd5_aab5;
    // One flip per zone in unit a, two per zone in unit b
    localparam logic [175:0] MASK_A =
        176'h8 | (176'h20 << 44) | (176'h40 << 88);
    localparam logic [175:0] MASK_B =
        176'h18 | (176'h18 << 66) | (176'h18 << 110);
    localparam row_t ROWS [7] = '{
        '{4'hc, 16'h1003, 16'h0077, 1'b0},
        '{4'hc, 16'h1004, 16'h2a35, 1'b0},
        '{4'hc, 16'h1005, 16'ha9d5, 1'b0},
        '{4'hc, 16'h1005, 16'ha9d5, 1'b0},
        '{4'hb, 16'h1003, 16'h0000, 1'b1},
        '{4'hc, 16'h1006, 16'h0000, 1'b1},
        '{4'hc, 16'h1002, 16'h0000, 1'b1}};
    logic        CLK;
    logic        RST;
    logic        a_req, b_req, a_ack, b_ack, a_err, b_err;
    logic [3:0]  a_mms, b_mms;
    logic [15:0] a_addr, b_addr, a_data, b_data, a_trim;
    logic        a_done, b_done, a_valid, b_valid, a_good, b_good;
    int          bad_count = 0;
    int          check_count = 0;
    int          cycles = 0;

    nvm_id_health #(.CONTENT(IMAGE), .FLIP_MASK(MASK_A)) i_dut (
        .CLK(CLK), .RST(RST), .RD_REQ(a_req), .RD_MMS(a_mms),
        .RD_ADDR(a_addr), .RD_ACK(a_ack), .RD_DATA(a_data),
        .RD_ERR(a_err), .LOAD_DONE(a_done), .ADDR_VALID(a_valid),
        .CFG_GUARANTEED(a_good), .CFG_TRIM(a_trim));
    nvm_id_health #(.CONTENT(IMAGE), .FLIP_MASK(MASK_B)) i_dut_b (
        .CLK(CLK), .RST(RST), .RD_REQ(b_req), .RD_MMS(b_mms),
        .RD_ADDR(b_addr), .RD_ACK(b_ack), .RD_DATA(b_data),
        .RD_ERR(b_err), .LOAD_DONE(b_done), .ADDR_VALID(b_valid),
        .CFG_GUARANTEED(b_good), .CFG_TRIM());
    nvm_host_model i_host_a (.clk(CLK), .rd_req(a_req), .rd_mms(a_mms),
        .rd_addr(a_addr), .rd_ack(a_ack), .rd_data(a_data),
        .rd_err(a_err));
    nvm_host_model i_host_b (.clk(CLK), .rd_req(b_req), .rd_mms(b_mms),
        .rd_addr(b_addr), .rd_ack(b_ack), .rd_data(b_data),
        .rd_err(b_err));

    // 100 MHz clock
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Counts falling edges after release until the load completes
    task automatic wait_load(output int n);
        n = 0;
        while (!a_done && n < 20) begin
            @(negedge CLK);
            n++;
        end
    endtask

    // Whole run needs about 40 cycles; a hang stops here at 3000
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            report_and_stop();
        end
    end

    initial begin
        logic [15:0] d;
        logic        e;
        logic        ok;
        int          n;
        RST = 1'b1;
        repeat (2) @(negedge CLK);
        check("reset_out", {14'h0, a_done, a_ack}, 16'h0000);
        RST = 1'b0;
        wait_load(n);
        check("load_edges", 16'(n), 16'h0009);
        $display("test reset done");
        // Ordinary reads of unit a, including refused selectors
        foreach (ROWS[i]) begin
            i_host_a.read(ROWS[i].mms, ROWS[i].addr, d, e, ok);
            check("row_data", d, ROWS[i].data);
            check("row_flags", {14'h0, ok, e}, {15'h1, ROWS[i].err});
        end
        check("host_addr", {8'h00, i_host_a.station_upper}, 16'h0077);
        check("a_trim", a_trim, 16'h1234);
        check("a_status", {13'h0, a_done, a_valid, a_good}, 16'h0007);
        $display("test single flips done");
        // Double flips in every zone
        i_host_b.read(MMS_SELECT, OFF_HEALTH, d, e, ok);
        check("b_health", d & 16'hfc00, 16'h5400);
        check("b_status", {13'h0, b_done, b_valid, b_good}, 16'h0004);
        $display("test double flips done");
        // Reset in mid-run rebuilds the flags from a fresh load
        RST = 1'b1;
        @(negedge CLK);
        check("rerun_clear", {15'h0, a_done}, 16'h0000);
        RST = 1'b0;
        wait_load(n);
        check("rerun_load", 16'(n), 16'h0009);
        i_host_a.read(MMS_SELECT, OFF_HEALTH, d, e, ok);
        check("rerun_health", d, 16'ha9d5);
        $display("test second reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
